/* shared/prv_pkg.sv */
// constants, memory map and state type for the program rom vector map
package prv_pkg;
  // widths and sizes
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ROM_WORDS = 6144;
  localparam int unsigned NUM_IRQ = 13;
  localparam int unsigned ACC_W = 8;
  localparam int unsigned WREG_N = 16;

  // program memory map
  localparam logic [12:0] RESET_VEC = 13'h0000;
  localparam logic [12:0] VEC_SLEEP = 13'h0008;
  localparam logic [12:0] VEC_EXT_A = 13'h0009;
  localparam logic [12:0] VEC_EXT_B = 13'h000A;
  localparam logic [12:0] VEC_BTIMER = 13'h000B;
  localparam logic [12:0] VEC_TC_A = 13'h000C;
  localparam logic [12:0] VEC_TC_B = 13'h000D;
  localparam logic [12:0] VEC_TC_C = 13'h000E;
  localparam logic [12:0] VEC_TIMER2 = 13'h000F;
  localparam logic [12:0] VEC_ADC = 13'h0010;
  localparam logic [12:0] VEC_SYNC_SER = 13'h0011;
  localparam logic [12:0] VEC_TWO_WIRE = 13'h0012;
  localparam logic [12:0] VEC_UART_RX = 13'h0013;
  localparam logic [12:0] VEC_UART_TX = 13'h0014;
  localparam logic [12:0] VEC_BASE = VEC_SLEEP;
  localparam logic [12:0] VEC_LAST = VEC_UART_TX;
  localparam logic [12:0] ISP_LO = 13'h0015;
  localparam logic [12:0] ISP_HI = 13'h177F;
  localparam logic [12:0] USER_HI = 13'h17F7;
  localparam logic [12:0] RSVD_LO = 13'h17F8;
  localparam logic [12:0] ROM_TOP = 13'h17FF;
  localparam logic [15:0] SECURE_DATA = 16'h0000;

  // interrupt request bit positions, lowest index serviced first
  localparam int IRQ_SLEEP = 0;
  localparam int IRQ_EXT_A = 1;
  localparam int IRQ_EXT_B = 2;
  localparam int IRQ_BTIMER = 3;
  localparam int IRQ_TC_A = 4;
  localparam int IRQ_TC_B = 5;
  localparam int IRQ_TC_C = 6;
  localparam int IRQ_TIMER2 = 7;
  localparam int IRQ_ADC = 8;
  localparam int IRQ_SYNC_SER = 9;
  localparam int IRQ_TWO_WIRE = 10;
  localparam int IRQ_UART_RX = 11;
  localparam int IRQ_UART_TX = 12;

  // reset cause flag layout
  localparam int CAUSE_PIN = 0;
  localparam int CAUSE_WDT = 1;
  localparam int CAUSE_POR = 2;
  localparam logic [2:0] CAUSE_NONE = 3'h0;
  localparam logic [2:0] CAUSE_PIN_ONLY = 3'h1;
  localparam logic [2:0] CAUSE_WDT_ONLY = 3'h2;
  localparam logic [2:0] CAUSE_POR_ONLY = 3'h4;

  // sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_RESET = 3'h1,
    ST_RUN = 3'h2,
    ST_ISR = 3'h4
  } prv_state_t;
endpackage

/* core/prv_flash_mem.sv */
// flash word array with a registered read port and a self-programming write port
`timescale 1ns/10ps
module prv_flash_mem #(
  parameter int unsigned AW = prv_pkg::ADDR_W,
  parameter int unsigned DW = prv_pkg::DATA_W,
  parameter int unsigned DEPTH = prv_pkg::ROM_WORDS
) (
  input wire logic sys_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data_r
);
  logic [DW-1:0] mem [DEPTH];
  logic rd_in;
  logic wr_in;

  // words above the array read as zero and are never written
  assign rd_in = (32'(rd_addr) < DEPTH); // [RQ14]
  assign wr_in = (32'(wr_addr) < DEPTH);

  // write port, no reset: flash contents survive every reset
  always_ff @(posedge sys_clk) begin
    if (wr_en && wr_in) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read data always leaves through a register
  always_ff @(posedge sys_clk) begin
    rd_data_r <= rd_in ? mem[rd_addr] : '0;
  end
endmodule

/* core/prv_vector_map.sv */
// program rom vector map: reset/interrupt vectoring, protection and reset cause
// How it works
// [RQ1] any reset restarts fetch at word zero
// [RQ2] words 0008 to 0014 hold interrupt vectors
// [RQ3] wake, pin a, pin b vector 0008-000A
// [RQ4] basic timer, counters a, b vector 000B-000D
// [RQ5] counter c, second timer, adc vector 000E-0010
// [RQ6] sync serial 0011, two wire port 0012
// [RQ7] uart receive 0013, uart transmit 0014
// [RQ8] self-programming only inside 0015 to 177F
// [RQ9] 1780 to 17F7 code only, never reprogrammed
// [RQ10] 17F8 to 17FF reserved, never reprogrammed
// [RQ11] secure mode reads even words as zero
// [RQ12] reset cause flags show the matching reset
// [RQ13] resets return system registers to defaults
// [RQ14] six k words, addresses 0000 to 17FF
// [RQ15] lowest pending vector address served first
// [RQ16] entry pushes pc then jumps to vector
// [RQ17] accumulator and working registers saved automatically
// [RQ18] only enabled requests, after instruction completes
`timescale 1ns/10ps
module prv_vector_map #(
  parameter int unsigned AW = prv_pkg::ADDR_W,
  parameter int unsigned DW = prv_pkg::DATA_W,
  parameter int unsigned NIRQ = prv_pkg::NUM_IRQ,
  parameter int unsigned ACCW = prv_pkg::ACC_W,
  parameter int unsigned WREGN = prv_pkg::WREG_N
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic rst_pin_n,
  input wire logic wdt_ovf,
  input wire logic brownout,
  input wire logic [NIRQ-1:0] irq_req,
  input wire logic [NIRQ-1:0] irq_en,
  input wire logic instr_done,
  input wire logic reti,
  input wire logic [AW-1:0] cur_pc,
  input wire logic [ACCW-1:0] acc_in,
  input wire logic [WREGN*ACCW-1:0] wreg_in,
  input wire logic fetch_req,
  input wire logic [AW-1:0] fetch_addr,
  input wire logic rd_req,
  input wire logic [AW-1:0] rd_addr,
  input wire logic rom_secure,
  input wire logic isp_req,
  input wire logic [AW-1:0] isp_addr,
  input wire logic [DW-1:0] isp_wdata,
  input wire logic cause_clr,
  output logic core_rst_r,
  output logic pc_load_r,
  output logic [AW-1:0] pc_value_r,
  output logic push_pc_r,
  output logic [AW-1:0] push_data_r,
  output logic [NIRQ-1:0] irq_ack_r,
  output logic ctx_save_r,
  output logic ctx_restore_r,
  output logic [ACCW-1:0] restore_acc_r,
  output logic [WREGN*ACCW-1:0] restore_wreg_r,
  output logic fetch_valid_r,
  output logic [DW-1:0] fetch_data_r,
  output logic rd_valid_r,
  output logic [DW-1:0] rd_data_r,
  output logic isp_done_r,
  output logic isp_err_r,
  output logic [2:0] reset_cause_flags_r
);
  prv_pkg::prv_state_t state_r;
  prv_pkg::prv_state_t state_nxt;
  logic pin_s1_r;
  logic pin_s2_r;
  logic pin_evt;
  logic any_evt;
  logic [NIRQ-1:0] pend;
  logic [NIRQ-1:0] winner;
  logic take;
  logic ret;
  logic leave_reset;
  logic [AW-1:0] pc_value_nxt;
  logic [ACCW-1:0] sh_acc_r;
  logic [WREGN*ACCW-1:0] sh_wreg_r;
  logic [2:0] cause_kept;
  logic [2:0] cause_nxt;
  logic isp_ok;
  logic [AW-1:0] mem_rd_addr;
  logic [DW-1:0] mem_q;
  logic fetch_p1_r;
  logic rd_p1_r;
  logic mask_p1_r;

  // isolate the lowest set bit: lowest index means highest priority
  function automatic logic [NIRQ-1:0] lowest(input logic [NIRQ-1:0] v);
    lowest = v & (~v + 1'b1);
  endfunction

  // vector word owned by a one-hot request
  function automatic logic [AW-1:0] vec_of(input logic [NIRQ-1:0] hot);
    vec_of = prv_pkg::VEC_BASE;
    for (int i = 0; i < NIRQ; i++) begin
      if (hot[i]) begin
        vec_of = prv_pkg::VEC_BASE + AW'(i);
      end
    end
  endfunction

  // the reset pin is asynchronous to sys_clk, two flops before use
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_s1_r <= 1'h1;
      pin_s2_r <= 1'h1;
    end else begin
      pin_s1_r <= rst_pin_n;
      pin_s2_r <= pin_s1_r;
    end
  end

  // reset events and interrupt selection
  assign pin_evt = !pin_s2_r;
  assign any_evt = pin_evt || wdt_ovf || brownout;
  assign pend = irq_req & irq_en; // [RQ18]
  assign winner = lowest(pend); // [RQ15]
  assign take = (state_r == prv_pkg::ST_RUN) && instr_done && (pend != '0) && !any_evt; // [RQ18]
  assign ret = (state_r == prv_pkg::ST_ISR) && reti && !any_evt;
  assign leave_reset = (state_r == prv_pkg::ST_RESET) && !any_evt;
  assign pc_value_nxt = take ? vec_of(winner) : prv_pkg::RESET_VEC; // [RQ1] [RQ2]

  // sequencer: a reset event overrides every state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      prv_pkg::ST_RESET: begin
        if (!any_evt) state_nxt = prv_pkg::ST_RUN;
      end
      prv_pkg::ST_RUN: begin
        if (take) state_nxt = prv_pkg::ST_ISR;
      end
      prv_pkg::ST_ISR: begin
        if (ret) state_nxt = prv_pkg::ST_RUN;
      end
      default: begin
        state_nxt = prv_pkg::ST_RESET;
      end
    endcase
    if (any_evt) state_nxt = prv_pkg::ST_RESET; // [RQ13]
  end

  // state and program counter redirection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= prv_pkg::ST_RESET;
      core_rst_r <= 1'h1;
      pc_load_r <= 1'h0;
      pc_value_r <= prv_pkg::RESET_VEC;
    end else begin
      state_r <= state_nxt;
      core_rst_r <= (state_nxt == prv_pkg::ST_RESET); // [RQ13]
      pc_load_r <= leave_reset || take; // [RQ1] [RQ16]
      pc_value_r <= pc_value_nxt;
    end
  end

  // interrupt entry: push, acknowledge, save context in the same edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      push_pc_r <= 1'h0;
      push_data_r <= prv_pkg::RESET_VEC;
      irq_ack_r <= '0;
      ctx_save_r <= 1'h0;
    end else begin
      push_pc_r <= take; // [RQ16]
      push_data_r <= take ? cur_pc : push_data_r;
      irq_ack_r <= take ? winner : '0; // [RQ15]
      ctx_save_r <= take; // [RQ17]
    end
  end

  // one shadow set is enough: a service routine is never interrupted
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sh_acc_r <= '0;
      sh_wreg_r <= '0;
      ctx_restore_r <= 1'h0;
      restore_acc_r <= '0;
      restore_wreg_r <= '0;
    end else begin
      sh_acc_r <= take ? acc_in : sh_acc_r; // [RQ17]
      sh_wreg_r <= take ? wreg_in : sh_wreg_r;
      ctx_restore_r <= ret; // [RQ17]
      restore_acc_r <= ret ? sh_acc_r : restore_acc_r;
      restore_wreg_r <= ret ? sh_wreg_r : restore_wreg_r;
    end
  end

  // reset cause: a new reset replaces the flags, a set beats a clear
  assign cause_kept = cause_clr ? prv_pkg::CAUSE_NONE : reset_cause_flags_r;
  assign cause_nxt = wdt_ovf ? prv_pkg::CAUSE_WDT_ONLY :
                     pin_evt ? prv_pkg::CAUSE_PIN_ONLY :
                     brownout ? prv_pkg::CAUSE_POR_ONLY : cause_kept; // [RQ12]

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      reset_cause_flags_r <= prv_pkg::CAUSE_POR_ONLY; // [RQ12]
    end else begin
      reset_cause_flags_r <= cause_nxt;
    end
  end

  // self-programming window; code-only and reserved words refuse writes
  assign isp_ok = (isp_addr >= prv_pkg::ISP_LO) && (isp_addr <= prv_pkg::ISP_HI); // [RQ8] [RQ9] [RQ10]

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      isp_done_r <= 1'h0;
      isp_err_r <= 1'h0;
    end else begin
      isp_done_r <= isp_req && isp_ok; // [RQ8]
      isp_err_r <= isp_req && !isp_ok;
    end
  end

  // one read port: instruction fetch wins, an external read that collides is dropped
  assign mem_rd_addr = fetch_req ? fetch_addr : rd_addr;

  prv_flash_mem #(
    .AW(AW),
    .DW(DW),
    .DEPTH(prv_pkg::ROM_WORDS)
  ) u_flash (
    .sys_clk(sys_clk),
    .wr_en(isp_req && isp_ok),
    .wr_addr(isp_addr),
    .wr_data(isp_wdata),
    .rd_addr(mem_rd_addr),
    .rd_data_r(mem_q)
  ); // [RQ14]

  // two-stage read pipe; the protection mask follows the address
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetch_p1_r <= 1'h0;
      rd_p1_r <= 1'h0;
      mask_p1_r <= 1'h0;
    end else begin
      fetch_p1_r <= fetch_req;
      rd_p1_r <= rd_req && !fetch_req;
      mask_p1_r <= rom_secure && !rd_addr[0]; // [RQ11]
    end
  end

  // fetch path is never masked; only the external read path is protected
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      fetch_valid_r <= 1'h0;
      fetch_data_r <= '0;
      rd_valid_r <= 1'h0;
      rd_data_r <= '0;
    end else begin
      fetch_valid_r <= fetch_p1_r;
      fetch_data_r <= fetch_p1_r ? mem_q : fetch_data_r;
      rd_valid_r <= rd_p1_r;
      rd_data_r <= rd_p1_r ? (mask_p1_r ? prv_pkg::SECURE_DATA : mem_q) : rd_data_r; // [RQ11]
    end
  end

  // checks
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  sequence s_reset_done;
    (state_r == prv_pkg::ST_RESET) && !any_evt;
  endsequence

  sequence s_take;
    (state_r == prv_pkg::ST_RUN) && instr_done && ((irq_req & irq_en) != '0) && !any_evt;
  endsequence

  sequence s_return;
    (state_r == prv_pkg::ST_ISR) && reti && !any_evt;
  endsequence

  rst_vector_a: assert property (s_reset_done |=> pc_load_r && (pc_value_r == '0)) // [RQ1]
    else $error("reset vector not loaded");

  vec_area_a: assert property ((irq_ack_r != '0) |-> // [RQ2]
      (pc_value_r >= prv_pkg::VEC_BASE) && (pc_value_r <= prv_pkg::VEC_LAST) && $onehot(irq_ack_r))
    else $error("vector outside interrupt area");

  vec_low_a: assert property ( // [RQ3]
      (irq_ack_r[prv_pkg::IRQ_SLEEP] |-> pc_value_r == prv_pkg::VEC_SLEEP) and
      (irq_ack_r[prv_pkg::IRQ_EXT_A] |-> pc_value_r == prv_pkg::VEC_EXT_A) and
      (irq_ack_r[prv_pkg::IRQ_EXT_B] |-> pc_value_r == prv_pkg::VEC_EXT_B))
    else $error("wake or pin vector wrong");

  vec_timer_a: assert property ( // [RQ4]
      (irq_ack_r[prv_pkg::IRQ_BTIMER] |-> pc_value_r == prv_pkg::VEC_BTIMER) and
      (irq_ack_r[prv_pkg::IRQ_TC_A] |-> pc_value_r == prv_pkg::VEC_TC_A) and
      (irq_ack_r[prv_pkg::IRQ_TC_B] |-> pc_value_r == prv_pkg::VEC_TC_B))
    else $error("timer vector wrong");

  vec_mid_a: assert property ( // [RQ5]
      (irq_ack_r[prv_pkg::IRQ_TC_C] |-> pc_value_r == prv_pkg::VEC_TC_C) and
      (irq_ack_r[prv_pkg::IRQ_TIMER2] |-> pc_value_r == prv_pkg::VEC_TIMER2) and
      (irq_ack_r[prv_pkg::IRQ_ADC] |-> pc_value_r == prv_pkg::VEC_ADC))
    else $error("counter or adc vector wrong");

  vec_serial_a: assert property ( // [RQ6]
      (irq_ack_r[prv_pkg::IRQ_SYNC_SER] |-> pc_value_r == prv_pkg::VEC_SYNC_SER) and
      (irq_ack_r[prv_pkg::IRQ_TWO_WIRE] |-> pc_value_r == prv_pkg::VEC_TWO_WIRE))
    else $error("serial vector wrong");

  vec_uart_a: assert property ( // [RQ7]
      (irq_ack_r[prv_pkg::IRQ_UART_RX] |-> pc_value_r == prv_pkg::VEC_UART_RX) and
      (irq_ack_r[prv_pkg::IRQ_UART_TX] |-> pc_value_r == prv_pkg::VEC_UART_TX))
    else $error("uart vector wrong");

  isp_range_a: assert property ((isp_done_r || isp_err_r) |-> // [RQ8]
      (isp_done_r == (($past(isp_addr) >= prv_pkg::ISP_LO) && ($past(isp_addr) <= prv_pkg::ISP_HI))))
    else $error("self-programming window wrong");

  secure_read_a: assert property ((rd_valid_r && $past(rom_secure, 2) && !$past(rd_addr[0], 2)) // [RQ11]
      |-> (rd_data_r == prv_pkg::SECURE_DATA))
    else $error("protected even word leaked");

  wdt_flag_a: assert property (wdt_ovf |=> reset_cause_flags_r == prv_pkg::CAUSE_WDT_ONLY) // [RQ12]
    else $error("watchdog cause not recorded");

  defaults_a: assert property (any_evt |=> core_rst_r ##1 (core_rst_r || pc_load_r)) // [RQ13]
    else $error("reset did not restore defaults");

  prio_order_a: assert property (s_take |=> ($onehot(irq_ack_r) && // [RQ15]
      ((irq_ack_r & $past(irq_req & irq_en)) != '0) &&
      (((irq_ack_r - 1'b1) & $past(irq_req & irq_en)) == '0)))
    else $error("wrong interrupt priority");

  push_entry_a: assert property (s_take |=> push_pc_r && pc_load_r && // [RQ16]
      (push_data_r == $past(cur_pc)))
    else $error("pc not pushed on entry");

  ctx_round_a: assert property (s_take |=> ctx_save_r ##0 (!ctx_restore_r)) // [RQ17]
    else $error("context not saved on entry");

  ctx_back_a: assert property (s_return |=> ctx_restore_r && (restore_acc_r == $past(sh_acc_r))) // [RQ17]
    else $error("context not restored on return");

  gate_entry_a: assert property ((irq_ack_r != '0) |-> $past(instr_done) && // [RQ18]
      (($past(irq_req) & $past(irq_en)) != '0))
    else $error("entry without enabled request");
endmodule

/* sim/prv_core_model.sv */
// core fetch side model: program counter, return stack and instruction pacing
`timescale 1ns/10ps
module prv_core_model (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic core_rst_r,
  input wire logic pc_load_r,
  input wire logic [12:0] pc_value_r,
  input wire logic push_pc_r,
  input wire logic [12:0] push_data_r,
  input wire logic slow,
  output logic instr_done,
  output logic [12:0] cur_pc,
  output logic [12:0] entry_pc,
  output logic [12:0] stack_top
);
  logic [12:0] prev_pc;

  // pc follows loads, else steps per finished instruction; slow mode stalls at random
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      instr_done <= 1'b0;
      cur_pc <= 13'h0000;
      prev_pc <= 13'h0000;
      entry_pc <= 13'h0000;
      stack_top <= 13'h0000;
    end else if (core_rst_r) begin
      instr_done <= 1'b0; // a held core finishes nothing
    end else begin
      instr_done <= slow ? ($urandom % 3 == 0) : 1'b1;
      if (instr_done) begin
        prev_pc <= cur_pc; // pc the entry edge saw
      end
      if (pc_load_r) begin
        cur_pc <= pc_value_r;
      end else if (instr_done) begin
        cur_pc <= cur_pc + 13'h0001;
      end
      if (push_pc_r) begin
        stack_top <= push_data_r;
        entry_pc <= prev_pc;
      end
    end
  end
endmodule

/* sim/prv_vector_map_test.sv */
// self-checking bench for the program rom vector map
`timescale 1ns/10ps
module prv_vector_map_test;
  logic sys_clk, resetn, rst_pin_n, wdt_ovf, brownout, instr_done, reti, slow;
  logic fetch_req, rd_req, rom_secure, isp_req, cause_clr;
  logic [12:0] irq_req, irq_en, cur_pc, fetch_addr, rd_addr, isp_addr, entry_pc, stack_top;
  logic [12:0] pc_value_r, push_data_r, irq_ack_r;
  logic [7:0] acc_in, restore_acc_r;
  logic [127:0] wreg_in, restore_wreg_r;
  logic [15:0] isp_wdata, fetch_data_r, rd_data_r;
  logic core_rst_r, pc_load_r, push_pc_r, ctx_save_r, ctx_restore_r;
  logic fetch_valid_r, rd_valid_r, isp_done_r, isp_err_r;
  logic [2:0] reset_cause_flags_r;
  logic [15:0] img [int];
  logic [12:0] edges [9] = '{13'h0000, 13'h0014, 13'h0015, 13'h0016, 13'h177F,
    13'h1780, 13'h17F7, 13'h17F8, 13'h17FF};
  int bad_count, num_checks;

  prv_vector_map dut (.sys_clk(sys_clk), .resetn(resetn), .rst_pin_n(rst_pin_n),
    .wdt_ovf(wdt_ovf), .brownout(brownout), .irq_req(irq_req), .irq_en(irq_en),
    .instr_done(instr_done), .reti(reti), .cur_pc(cur_pc), .acc_in(acc_in),
    .wreg_in(wreg_in), .fetch_req(fetch_req), .fetch_addr(fetch_addr), .rd_req(rd_req),
    .rd_addr(rd_addr), .rom_secure(rom_secure), .isp_req(isp_req), .isp_addr(isp_addr),
    .isp_wdata(isp_wdata), .cause_clr(cause_clr), .core_rst_r(core_rst_r),
    .pc_load_r(pc_load_r), .pc_value_r(pc_value_r), .push_pc_r(push_pc_r),
    .push_data_r(push_data_r), .irq_ack_r(irq_ack_r), .ctx_save_r(ctx_save_r),
    .ctx_restore_r(ctx_restore_r), .restore_acc_r(restore_acc_r),
    .restore_wreg_r(restore_wreg_r), .fetch_valid_r(fetch_valid_r),
    .fetch_data_r(fetch_data_r), .rd_valid_r(rd_valid_r), .rd_data_r(rd_data_r),
    .isp_done_r(isp_done_r), .isp_err_r(isp_err_r),
    .reset_cause_flags_r(reset_cause_flags_r));

  prv_core_model u_core (.sys_clk(sys_clk), .resetn(resetn), .core_rst_r(core_rst_r),
    .pc_load_r(pc_load_r), .pc_value_r(pc_value_r), .push_pc_r(push_pc_r),
    .push_data_r(push_data_r), .slow(slow), .instr_done(instr_done), .cur_pc(cur_pc),
    .entry_pc(entry_pc), .stack_top(stack_top));

  // 50 ns period
  always #25 sys_clk = ~sys_clk;

  // narrow compares widen into the one reporting task
  task automatic chk_wide(string n, logic [135:0] e, logic [135:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_bit(string n, logic e, logic g);
    chk_wide(n, {135'h0, e}, {135'h0, g});
  endtask
  task automatic chk_addr(string n, logic [12:0] e, logic [12:0] g);
    chk_wide(n, {123'h0, e}, {123'h0, g});
  endtask
  task automatic chk_word(string n, logic [15:0] e, logic [15:0] g);
    chk_wide(n, {120'h0, e}, {120'h0, g});
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // expectations, lowest pending index wins
  function automatic logic [12:0] exp_vec(logic [12:0] pend);
    for (int i = 0; i < 13; i++) begin
      if (pend[i]) return prv_pkg::VEC_BASE + 13'(i);
    end
    return prv_pkg::RESET_VEC;
  endfunction
  function automatic logic isp_ok(logic [12:0] a);
    return a >= prv_pkg::ISP_LO && a <= prv_pkg::ISP_HI;
  endfunction
  function automatic logic [15:0] exp_rd(logic f, logic sec, logic [12:0] a);
    if (a > prv_pkg::ROM_TOP) return 16'h0000;
    if (!f && sec && !a[0]) return prv_pkg::SECURE_DATA;
    return img[a];
  endfunction

  task automatic isp_wr(logic [12:0] a, logic [15:0] d);
    @(posedge sys_clk);
    isp_req <= 1'b1;
    isp_addr <= a;
    isp_wdata <= d;
    @(posedge sys_clk);
    isp_req <= 1'b0;
    // the answer pulse stands for the one cycle right after the request edge
    #1;
    chk_bit("isp_done_r", isp_ok(a), isp_done_r);
    chk_bit("isp_err_r", !isp_ok(a), isp_err_r);
    if (isp_ok(a)) img[a] = d;
  endtask

  task automatic mem_rd(logic f, logic sec, logic [12:0] a);
    @(posedge sys_clk);
    fetch_req <= f;
    rd_req <= !f;
    fetch_addr <= a;
    rd_addr <= a;
    rom_secure <= sec;
    @(posedge sys_clk);
    fetch_req <= 1'b0;
    rd_req <= 1'b0;
    // valid is a one-cycle pulse one edge after the request is taken
    @(posedge sys_clk);
    #1;
    chk_bit("read valid", 1'b1, f ? fetch_valid_r : rd_valid_r);
    chk_word("read data", exp_rd(f, sec, a), f ? fetch_data_r : rd_data_r);
  endtask

  // entry, pushed pc, context round trip; with nothing pending no reti is sent and no restore may follow
  task automatic irq_run(logic [12:0] req, logic [12:0] en);
    logic [12:0] pend;
    logic [7:0] acc;
    logic [127:0] wr;
    int n;
    pend = req & en;
    acc = 8'($urandom);
    wr = {$urandom, $urandom, $urandom, $urandom};
    @(posedge sys_clk);
    irq_req <= req;
    irq_en <= en;
    acc_in <= acc;
    wreg_in <= wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (irq_ack_r === 13'h0000 && n < 40);
    chk_addr("irq_ack_r", pend & (~pend + 13'h0001), irq_ack_r);
    if (pend != 13'h0000) begin
      chk_addr("pc_value_r", exp_vec(pend), pc_value_r);
      chk_bit("pc_load_r", 1'b1, pc_load_r);
      chk_bit("push_pc_r", 1'b1, push_pc_r);
      chk_bit("ctx_save_r", 1'b1, ctx_save_r);
    end
    @(posedge sys_clk);
    irq_req <= 13'h0000;
    acc_in <= ~acc;
    wreg_in <= ~wr;
    reti <= (pend != 13'h0000);
    // the model records the entry pc only on the edge that sees the push
    #1;
    if (pend != 13'h0000) chk_addr("push_data_r", entry_pc, push_data_r);
    @(posedge sys_clk);
    reti <= 1'b0;
    #1;
    chk_bit("ctx_restore_r", pend != 13'h0000, ctx_restore_r);
    if (pend != 13'h0000) chk_wide("context", {acc, wr}, {restore_acc_r, restore_wreg_r});
  endtask

  // k: 0 watchdog, 1 pin, 2 brownout
  task automatic rst_ev(int k);
    logic seen;
    int n;
    seen = 1'b0;
    @(posedge sys_clk);
    wdt_ovf <= (k == 0);
    rst_pin_n <= (k != 1);
    brownout <= (k == 2);
    repeat (4) begin
      @(posedge sys_clk);
      #1;
      seen |= core_rst_r;
    end
    // release on a rising edge like every other input change
    @(posedge sys_clk);
    wdt_ovf <= 1'b0;
    rst_pin_n <= 1'b1;
    brownout <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (pc_load_r !== 1'b1 && n < 12);
    chk_bit("core_rst_r held", 1'b1, seen);
    chk_bit("pc_load_r", 1'b1, pc_load_r);
    chk_addr("pc_value_r", prv_pkg::RESET_VEC, pc_value_r);
    chk_wide("cause", {133'h0, k == 0 ? prv_pkg::CAUSE_WDT_ONLY : k == 1 ?
      prv_pkg::CAUSE_PIN_ONLY : prv_pkg::CAUSE_POR_ONLY}, {133'h0, reset_cause_flags_r});
  endtask

  // main sequence
  initial begin
    {sys_clk, resetn, wdt_ovf, brownout, reti, slow, fetch_req, rd_req} = 8'h00;
    {rom_secure, isp_req, cause_clr, rst_pin_n} = 4'h1;
    {irq_req, irq_en, fetch_addr, rd_addr, isp_addr} = 65'h0;
    {acc_in, wreg_in, isp_wdata} = 152'h0;
    bad_count = 0;
    num_checks = 0;
    void'($urandom(32'h39f52ff1));
    repeat (9) @(posedge sys_clk);
    #1;
    chk_bit("core_rst_r", 1'b1, core_rst_r);
    chk_wide("cause", {133'h0, prv_pkg::CAUSE_POR_ONLY}, {133'h0, reset_cause_flags_r});
    @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    #1;
    chk_bit("pc_load_r", 1'b1, pc_load_r);
    chk_addr("pc_value_r", prv_pkg::RESET_VEC, pc_value_r);
    $display("test power_on done");
    for (int k = 0; k < 3; k++) rst_ev(k);
    @(posedge sys_clk);
    cause_clr <= 1'b1;
    @(posedge sys_clk);
    cause_clr <= 1'b0;
    @(posedge sys_clk);
    #1;
    chk_wide("cause", {133'h0, prv_pkg::CAUSE_NONE}, {133'h0, reset_cause_flags_r});
    $display("test reset_events done");
    foreach (edges[i]) isp_wr(edges[i], 16'($urandom));
    repeat (16) isp_wr(prv_pkg::ISP_LO + 13'($urandom % 32), 16'($urandom));
    foreach (img[a]) begin
      for (int m = 0; m < 4; m++) mem_rd(m[0], m[1], 13'(a));
    end
    mem_rd(1'b0, 1'b0, 13'h1800);
    mem_rd(1'b1, 1'b1, 13'h1FFE);
    $display("test rom_access done");
    for (int i = 0; i < 13; i++) irq_run(13'h0001 << i, 13'h1FFF);
    irq_run(13'h1FFF, 13'h1FFF);
    irq_run(13'h0090, 13'h1FFF);
    irq_run(13'h0010, 13'h1FEF);
    slow = 1'b1;
    repeat (30) irq_run(13'($urandom), 13'($urandom));
    $display("test vectoring done");
    test_done;
  end

  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #(50 * 40000);
    $display("watchdog expired");
    bad_count++;
    test_done;
  end
endmodule
